// ---- inc/pwt_pkg.sv ----
`default_nettype none
package pwt_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [7:0] PWT_OFS_CTRL = 8'h00;
	localparam logic [7:0] PWT_OFS_COUNT = 8'h04;
	localparam logic [7:0] PWT_OFS_CCCTL = 8'h08;
	localparam logic [7:0] PWT_OFS_CMPA = 8'h0C;
	localparam logic [7:0] PWT_OFS_CMPB = 8'h10;
	localparam logic [7:0] PWT_OFS_STAT = 8'h14;
	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int PWT_CTL_RUN = 0;
	localparam int PWT_CTL_CLR = 1;
	localparam int PWT_CTL_MODE = 2;
	localparam int PWT_CTL_HCM = 3;
	localparam int PWT_CTL_DIV_LO = 4;
	// ----------------------------------------
	// compare/capture control fields
	// ----------------------------------------
	localparam int PWT_CC_CAPA = 0;
	localparam int PWT_CC_CAPB = 1;
	localparam int PWT_CC_AMD_LO = 2;
	localparam int PWT_CC_BMD_LO = 4;
	localparam int PWT_CC_AINV = 6;
	localparam int PWT_CC_BINV = 7;
	// ----------------------------------------
	// reset values and encodings
	// ----------------------------------------
	localparam logic [15:0] PWT_RST_CMP = 16'h0000;
	localparam logic [3:0] PWT_RST_DIV = 4'h0;
	localparam logic [1:0] PWT_RESP_OKAY = 2'h0;
	localparam logic [1:0] PWT_RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		PWT_OUT_OFF = 2'b00,
		PWT_OUT_SETCLR = 2'b01,
		PWT_OUT_TOG_A = 2'b10,
		PWT_OUT_TOG_B = 2'b11
	} pwt_omode_t;
endpackage
`default_nettype wire

// ---- rtl/pwt_timer.sv ----
// Contract
// - mode bit 0: counter keeps counting and wraps until software stops it
// - mode bit 1: counter stops itself when compare B match fires
// - half clock on: dual-edge counter drives compare A, doubling resolution
// - half clock off: compare A fires when main counter equals compare A
// - dual-edge counter value is never readable
// - writing 1 to clear forces counter to 0
// - counter returns to 0 after reaching compare B
// - run 1 starts counting, run 0 gates count clock and halts
// - stopping keeps counter value, restart continues from it
// - run and clear written together: clear first, then count
// - counter readable while running in one whole-word access
// - two independent outputs both driven by compare A and B
// - mode 3 toggles on B, 2 toggles on A, 1 sets A clears B, 0 off
// - outputs active high, invert bit makes them active low
// - clearing counter drives both outputs to inactive level
// - a compare in capture mode produces no match
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module pwt_timer
	import pwt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic timer_output_a,
	output logic timer_output_b
);
	// ----------------------------------------
	// functions
	// ----------------------------------------
	// next raw level of one output circuit
	function automatic logic lvl_fn(input logic [1:0] md, input logic lv, input logic ma,
		input logic mb);
		case (md)
			PWT_OUT_SETCLR: lvl_fn = mb ? 1'b0 : (ma ? 1'b1 : lv);
			PWT_OUT_TOG_A: lvl_fn = ma ? ~lv : lv;
			PWT_OUT_TOG_B: lvl_fn = mb ? ~lv : lv;
			default: lvl_fn = 1'b0;
		endcase
	endfunction

	// pin level: off mode sits inactive, invert flips polarity
	function automatic logic pin_fn(input logic [1:0] md, input logic inv, input logic lv);
		pin_fn = (md == PWT_OUT_OFF) ? inv : (lv ^ inv);
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic run, mode_os, half_clock_select, cap_a, cap_b, inv_a, inv_b, lvl_a, lvl_b, phase;
	logic [3:0] div;
	logic [1:0] md_a, md_b;
	logic [15:0] cnt, cmpa, cmpb, pre;
	logic [16:0] dcnt;
	logic aw_held, w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	// ----------------------------------------
	// axi write channel
	// ----------------------------------------
	logic wr_go, wr_ctrl, wr_hit, clr, run_set;
	logic [7:0] wa;
	logic [31:0] wd;
	logic [3:0] ws;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	assign wa = aw_held ? aw_addr : s_axi_awaddr;
	assign wd = w_held ? w_data : s_axi_wdata;
	assign ws = w_held ? w_strb : s_axi_wstrb;
	// write commits once both halves are present, either order
	assign wr_go = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
	assign wr_hit = (wa == PWT_OFS_CTRL) || (wa == PWT_OFS_CCCTL) || (wa == PWT_OFS_CMPA)
		|| (wa == PWT_OFS_CMPB) || (wa == PWT_OFS_COUNT) || (wa == PWT_OFS_STAT);
	assign wr_ctrl = wr_go && (wa == PWT_OFS_CTRL) && ws[0];
	assign clr = wr_ctrl && wd[PWT_CTL_CLR];
	assign run_set = wr_ctrl && wd[PWT_CTL_RUN];

	// hold address/data halves until the pair is complete
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (wr_go) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end

	// write response; read-only offsets accept and ignore
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= PWT_RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? PWT_RESP_OKAY : PWT_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	// mode, compare and output setup; clear bit is a pulse, never stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_os <= 1'b0;
			half_clock_select <= 1'b0;
			div <= PWT_RST_DIV;
			cap_a <= 1'b0;
			cap_b <= 1'b0;
			md_a <= PWT_OUT_OFF;
			md_b <= PWT_OUT_OFF;
			inv_a <= 1'b0;
			inv_b <= 1'b0;
			cmpa <= PWT_RST_CMP;
			cmpb <= PWT_RST_CMP;
		end else if (wr_go) begin
			if (wa == PWT_OFS_CTRL && ws[0]) begin
				mode_os <= wd[PWT_CTL_MODE];
				half_clock_select <= wd[PWT_CTL_HCM];
				div <= wd[PWT_CTL_DIV_LO +: 4];
			end
			if (wa == PWT_OFS_CCCTL && ws[0]) begin
				cap_a <= wd[PWT_CC_CAPA];
				cap_b <= wd[PWT_CC_CAPB];
				md_a <= wd[PWT_CC_AMD_LO +: 2];
				md_b <= wd[PWT_CC_BMD_LO +: 2];
				inv_a <= wd[PWT_CC_AINV];
				inv_b <= wd[PWT_CC_BINV];
			end
			if (wa == PWT_OFS_CMPA) begin
				if (ws[0]) cmpa[7:0] <= wd[7:0];
				if (ws[1]) cmpa[15:8] <= wd[15:8];
			end
			if (wa == PWT_OFS_CMPB) begin
				if (ws[0]) cmpb[7:0] <= wd[7:0];
				if (ws[1]) cmpb[15:8] <= wd[15:8];
			end
		end
	end

	// ----------------------------------------
	// count clock: half ticks from a prescaler
	// ----------------------------------------
	logic half_tick, full_tick;
	logic [15:0] pre_top;

	// one count clock period is two half ticks, so both edges exist
	assign pre_top = 16'((32'd1 << div) - 32'd1);
	assign half_tick = run && !clr && (pre == pre_top);
	assign full_tick = half_tick && phase;

	// prescaler frozen while stopped so a restart resumes mid-period
	always_ff @(posedge aclk) begin
		if (!aresetn || clr) begin
			pre <= 16'h0000;
			phase <= 1'b0;
		end else if (run) begin
			pre <= half_tick ? 16'h0000 : 16'(pre + 16'h0001);
			if (half_tick) phase <= ~phase;
		end
	end

	// ----------------------------------------
	// counters and compare matches
	// ----------------------------------------
	logic wrap, match_a, match_b;
	logic [15:0] next_cnt;
	logic [16:0] next_dcnt;

	assign wrap = (cnt == cmpb) && !cap_b;
	assign next_cnt = wrap ? 16'h0000 : 16'(cnt + 16'h0001);
	assign next_dcnt = (full_tick && wrap) ? 17'h00000 : 17'(dcnt + 17'h00001);
	// matches fire on the edge where the value is reached
	assign match_b = full_tick && !cap_b && (next_cnt == cmpb);
	assign match_a = !cap_a && (half_clock_select ? (half_tick && next_dcnt == {1'b0, cmpa})
		: (full_tick && next_cnt == cmpa));

	// main counter: clear beats counting, stop holds value
	always_ff @(posedge aclk) begin
		if (!aresetn || clr) begin
			cnt <= 16'h0000;
		end else if (full_tick) begin
			cnt <= next_cnt;
		end
	end

	// dual-edge counter is internal only, no read path reaches it
	always_ff @(posedge aclk) begin
		if (!aresetn || clr) begin
			dcnt <= 17'h00000;
		end else if (half_tick) begin
			dcnt <= next_dcnt;
		end
	end

	// run flag: software start beats the one-shot stop
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run <= 1'b0;
		end else if (wr_ctrl) begin
			run <= wd[PWT_CTL_RUN];
		end else if (match_b && mode_os) begin
			run <= 1'b0;
		end
	end

	// ----------------------------------------
	// timer outputs
	// ----------------------------------------
	logic next_lvl_a, next_lvl_b;

	assign next_lvl_a = clr ? 1'b0 : lvl_fn(md_a, lvl_a, match_a, match_b);
	assign next_lvl_b = clr ? 1'b0 : lvl_fn(md_b, lvl_b, match_a, match_b);

	// pins registered to stay glitch free on the way to the pads
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lvl_a <= 1'b0;
			lvl_b <= 1'b0;
			timer_output_a <= 1'b0;
			timer_output_b <= 1'b0;
		end else begin
			lvl_a <= next_lvl_a;
			lvl_b <= next_lvl_b;
			timer_output_a <= pin_fn(md_a, inv_a, next_lvl_a);
			timer_output_b <= pin_fn(md_b, inv_b, next_lvl_b);
		end
	end

	// ----------------------------------------
	// axi read channel
	// ----------------------------------------
	// whole-word read returns all 16 counter bits at once
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= PWT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= PWT_RESP_OKAY;
			case (s_axi_araddr)
				PWT_OFS_CTRL: s_axi_rdata <= {24'h000000, div, half_clock_select, mode_os, 1'b0, run};
				PWT_OFS_COUNT: s_axi_rdata <= {16'h0000, cnt};
				PWT_OFS_CCCTL: s_axi_rdata <= {24'h000000, inv_b, inv_a, md_b, md_a, cap_b,
					cap_a};
				PWT_OFS_CMPA: s_axi_rdata <= {16'h0000, cmpa};
				PWT_OFS_CMPB: s_axi_rdata <= {16'h0000, cmpb};
				PWT_OFS_STAT: s_axi_rdata <= {29'h00000000, timer_output_b, timer_output_a,
					run};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= PWT_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	assign s_axi_arready = !s_axi_rvalid;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_clear_forces_zero: assert property (clr |=> cnt == 16'h0000 ##1 1)
		else $error("counter not zero after clear");
	a_stop_holds_count: assert property (!run && !clr |=> $stable(cnt))
		else $error("counter moved while stopped");
	a_wrap_at_cmpb: assert property (full_tick && wrap |=> cnt == 16'h0000)
		else $error("counter did not wrap at compare B");
	a_oneshot_stops: assert property (match_b && mode_os && !wr_ctrl |=> !run)
		else $error("one-shot did not stop");
	a_repeat_keeps: assert property (run && !mode_os && !wr_ctrl |=> run)
		else $error("repeat mode stopped by itself");
	a_run_after_clr: assert property (run_set && clr |=> run && cnt == 16'h0000)
		else $error("run with clear misordered");
	a_clear_inactive: assert property (clr |=> timer_output_a == inv_a
		&& timer_output_b == inv_b)
		else $error("outputs not inactive after clear");
	a_capture_silent: assert property (cap_a |-> !match_a)
		else $error("compare A match in capture mode");
	a_toggle_a_flip: assert property (md_a == PWT_OUT_TOG_A && match_a && !clr
		|=> lvl_a != $past(lvl_a))
		else $error("output A did not toggle on compare A");
	a_normal_cmpa: assert property (match_a && !half_clock_select |-> full_tick && next_cnt == cmpa)
		else $error("normal compare A off its edge");
	a_half_cmpa: assert property (match_a && half_clock_select |-> half_tick)
		else $error("half clock compare A off a half edge");
	// pin level must track mode and polarity, not just the raw level flops
	a_off_inactive: assert property (md_a == PWT_OUT_OFF
		|=> timer_output_a == $past(inv_a))
		else $error("disabled output A not at inactive level");
	a_polarity_b: assert property (md_b != PWT_OUT_OFF
		|=> timer_output_b == (lvl_b ^ $past(inv_b)))
		else $error("output B polarity wrong");
	a_setclr_b_low: assert property (md_b == PWT_OUT_SETCLR && match_b |=> !lvl_b)
		else $error("set/clear output B not cleared on compare B");
endmodule
`default_nettype wire

// ---- verif/pwt_load.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// external load on one timer pin
// ----------------------------------------
module pwt_load (
	input wire logic aclk,
	input wire logic level,
	output logic [15:0] period,
	output logic [15:0] high_time,
	output logic [15:0] rises
);
	logic last;
	logic [15:0] run_len;
	logic [15:0] hi_len;
	// a load only listens, it never drives the pin back
	initial begin
		last = 1'b0;
		period = 16'h0000;
		high_time = 16'h0000;
		rises = 16'h0000;
		run_len = 16'h0000;
		hi_len = 16'h0000;
	end
	// span between rising edges and its high part, in aclk samples
	always @(posedge aclk) begin
		last <= level;
		if (level === 1'b1 && last === 1'b0) begin
			period <= run_len;
			high_time <= hi_len;
			rises <= rises + 16'h0001;
			run_len <= 16'h0001;
			hi_len <= 16'h0001;
		end else begin
			run_len <= run_len + 16'h0001;
			hi_len <= hi_len + {15'h0000, level};
		end
	end
endmodule
`default_nettype wire

// ---- verif/pwm_timer_count_and_output_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module pwm_timer_count_and_output_test
	import pwt_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h00000000;
	logic awready, wready, bvalid, arready, rvalid, out_a, out_b;
	logic [1:0] bresp, rresp, wr_resp, rd_resp;
	logic [31:0] rdata, v, w;
	logic [31:0] seed = 32'hB07F253F;
	logic [15:0] per_a, hi_a, rise_a, per_b, hi_b, rise_b, a, b;
	int errors = 0;
	int check_count = 0;
	always #2 aclk = ~aclk;
	pwt_timer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .timer_output_a(out_a), .timer_output_b(out_b));
	pwt_load load_a (.aclk(aclk), .level(out_a), .period(per_a), .high_time(hi_a),
		.rises(rise_a));
	pwt_load load_b (.aclk(aclk), .level(out_b), .period(per_b), .high_time(hi_b),
		.rises(rise_b));
	// ----------------------------------------
	// expectations
	// ----------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// toggle modes halve the pin rate compared with set/clear mode
	function automatic logic [31:0] exp_per(input logic [1:0] md, input logic [15:0] cb);
		return (md == 2'h1) ? 32'h2 * (cb + 32'h1) : 32'h4 * (cb + 32'h1);
	endfunction
	// half mode compares a at half-tick grain, so a counts in aclk cycles here
	function automatic logic [31:0] exp_hi(input logic [1:0] md, input logic inv,
		input logic half_clock_select, input logic [15:0] ca, input logic [15:0] cb);
		logic [31:0] h;
		if (md != 2'h1) return 32'h2 * (cb + 32'h1);
		h = half_clock_select ? 32'h2 * cb - ca : 32'h2 * (cb - ca);
		return inv ? exp_per(md, cb) - h : h;
	endfunction
	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] ad, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= ad;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		wr_resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [31:0] d);
		@(posedge aclk);
		araddr <= ad;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		rd_resp = rresp;
		rready <= 1'b0;
	endtask
	// one pwm setup at divider d, started with run and clear together
	// every span scales by 2^d since a half tick lasts 2^d aclk cycles
	task automatic meas(input logic [7:0] cc, input logic half_clock_select, input logic [3:0] d);
		seed = lfsr(seed);
		b = 16'h0002 + 16'(seed[2:0]);
		a = 16'h0001 + 16'(seed[10:8]) % (b - 16'h0001);
		wr(PWT_OFS_CTRL, {24'h0, d, half_clock_select, 3'b010});
		wr(PWT_OFS_CCCTL, {24'h0, cc});
		wr(PWT_OFS_CMPA, {16'h0, a});
		wr(PWT_OFS_CMPB, {16'h0, b});
		wr(PWT_OFS_CTRL, {24'h0, d, half_clock_select, 3'b011});
		repeat ((24 * (b + 16'h0001)) << d) @(posedge aclk);
		chk(32'(per_a), exp_per(cc[3:2], b) << d);
		chk(32'(hi_a), exp_hi(cc[3:2], cc[6], half_clock_select, a, b) << d);
		chk(32'(per_b), exp_per(cc[5:4], b) << d);
		chk(32'(hi_b), exp_hi(cc[5:4], cc[7], half_clock_select, a, b) << d);
		rd(PWT_OFS_COUNT, v);
		chk(32'(v <= 32'(b)), 32'h1);
		rd(PWT_OFS_STAT, v);
		chk(32'(v[0]), 32'h1);
		wr(PWT_OFS_CTRL, {24'h0, d, half_clock_select, 3'b000});
		rd(PWT_OFS_COUNT, v);
		repeat (8) @(posedge aclk);
		rd(PWT_OFS_COUNT, w);
		chk(w, v);
		wr(PWT_OFS_CTRL, {24'h0, d, half_clock_select, 3'b011});
		rd(PWT_OFS_COUNT, v);
		chk(32'(v <= 32'h3), 32'h1);
		wr(PWT_OFS_CTRL, {24'h0, d, half_clock_select, 3'b010});
		rd(PWT_OFS_COUNT, v);
		chk(v, 32'h0);
		chk(32'({out_b, out_a}), 32'({cc[7], cc[6]}));
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge aclk);
		errors++;
		wrap_up();
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rd(8'(4 * i), v);
			chk(v, 32'h0);
		end
		// unmapped place: refused, nothing leaks out
		rd(8'h18, v);
		chk(v, 32'h0);
		chk(32'(rd_resp), 32'(PWT_RESP_SLVERR));
		wr(8'h18, 32'hFFFFFFFF);
		chk(32'(wr_resp), 32'(PWT_RESP_SLVERR));
		meas(8'h94, 1'b0, 4'h0);
		meas(8'h14, 1'b1, 4'h2);
		meas(8'h78, 1'b0, 4'h1);
		// one-shot stops itself holding compare b
		wr(PWT_OFS_CTRL, 32'h00000006);
		wr(PWT_OFS_CTRL, 32'h00000005);
		repeat (4 * (b + 16'h0001)) @(posedge aclk);
		rd(PWT_OFS_COUNT, v);
		chk(v, 32'(b));
		rd(PWT_OFS_STAT, v);
		chk(32'(v[0]), 32'h0);
		// capture on both compares: toggle-on-a pin stays put, no wrap at b
		wr(PWT_OFS_CCCTL, 32'h0000008B);
		wr(PWT_OFS_CTRL, 32'h00000002);
		wr(PWT_OFS_CTRL, 32'h00000001);
		w = 32'(rise_a);
		repeat (40) @(posedge aclk);
		chk(32'(rise_a), w);
		chk(32'({out_b, out_a}), 32'h2);
		rd(PWT_OFS_COUNT, v);
		chk(32'(v > 32'(b)), 32'h1);
		wrap_up();
	end
endmodule
`default_nettype wire
